//--- hdl/hpr_pkg.sv
// Package for the host power and reset watchdog block.
// Holds register map, command codes, timing constants, states and carriers.
package hpr_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_HZ = 32;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

    // Times in milliseconds, converted to 1/32 s ticks
    localparam int unsigned RESET_HOLD_MS = 4000;
    localparam int unsigned PWR_ON_HOLD_MS = 250;
    localparam int unsigned PWR_OFF_HOLD_MS = 4000;
    localparam int unsigned RESET_PULSE_MS = 1000;
    localparam int unsigned EXTEND_MAX_MS = 5000;
    localparam int unsigned WD_UNIT_MS = 1000;
    localparam logic [7:0] RESET_HOLD_TK = 8'((RESET_HOLD_MS * TICK_HZ) / 1000);
    localparam logic [7:0] PWR_ON_HOLD_TK = 8'((PWR_ON_HOLD_MS * TICK_HZ) / 1000);
    localparam logic [7:0] PWR_OFF_HOLD_TK = 8'((PWR_OFF_HOLD_MS * TICK_HZ) / 1000);
    localparam logic [7:0] RESET_PULSE_TK = 8'((RESET_PULSE_MS * TICK_HZ) / 1000);
    localparam logic [7:0] EXTEND_MAX_TK = 8'((EXTEND_MAX_MS * TICK_HZ) / 1000);
    localparam int unsigned WD_SHIFT = 5;
    localparam int unsigned WD_UNIT_TK = (WD_UNIT_MS * TICK_HZ) / 1000;
    localparam logic [7:0] PULSE_LEN_DEFAULT = 8'h20;

    // Wishbone register byte offsets
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_REPLY = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_CONFIG = 8'h0c;
    localparam logic [3:0] SEL_ALL = 4'hf;

    // Command and reply codes
    localparam logic [7:0] CMD_SWITCH = 8'h1c;
    localparam logic [7:0] CMD_WATCHDOG = 8'h1d;
    localparam logic [7:0] RPL_OK = 8'h40;
    localparam logic [7:0] RPL_ERR = 8'hc0;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;

    // Function mask bits
    localparam int unsigned FN_AUTO_POL = 0;
    localparam int unsigned FN_RESET_INV = 1;
    localparam int unsigned FN_POWER_INV = 2;
    localparam int unsigned FN_BLANK = 4;
    localparam int unsigned FN_KEY_RESET = 5;
    localparam int unsigned FN_KEY_PWR_ON = 6;
    localparam int unsigned FN_KEY_PWR_OFF = 7;
    localparam logic [7:0] FUNC_RESET_VAL = 8'h00;

    typedef enum logic [2:0] {
        MSG_NONE,
        MSG_BOOT,
        MSG_RESET,
        MSG_POWER_ON,
        MSG_POWER_OFF
    } hpr_msg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_PULSE,
        ST_PWR_PULSE,
        ST_PWR_EXTEND,
        ST_REBOOT
    } hpr_state_t;

    // Command word written to ADR_CMD
    typedef struct packed {
        logic [5:0] pad;
        logic [1:0] len;
        logic [7:0] data1;
        logic [7:0] data0;
        logic [7:0] kind;
    } hpr_cmd_t;

    // Word read from ADR_STATUS
    typedef struct packed {
        logic [7:0] pad;
        logic [7:0] wd_secs;
        logic [5:0] pad2;
        logic rst_drive;
        logic pwr_drive;
        logic wd_en;
        logic lockout;
        hpr_msg_t msg;
        logic backlight;
        logic blank;
        logic sense;
    } hpr_status_t;

endpackage

//--- hdl/hpr_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module hpr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_clk,        // System clock
    input wire logic i_rstn,       // Async reset, active low
    input wire logic [W-1:0] i_d,  // Asynchronous levels
    output logic [W-1:0] o_q       // Synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

//--- hdl/hpr_tick.sv
// Prescaler giving a one-cycle pulse every CYCLES clocks (1/32 s base).
// Assumes a free-running clock; restart realigns the phase to zero.
`timescale 1ns/1ps
module hpr_tick #(
    parameter int unsigned CYCLES = 312500
) (
    input wire logic i_clk,    // System clock
    input wire logic i_rstn,   // Async reset, active low
    input wire logic i_clear,  // Restart the prescaler
    output logic o_tick        // One-cycle tick pulse
);
    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else if (i_clear) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

//--- hdl/hpr_top.sv
// Host power / reset switch controller with keypad actions and watchdog.
// Assumes a classic Wishbone master, pins synchronised here, pad logic
// outside resolving the three-signal pins into tri-state wires.
// Summary of operation
// - Pulse lines idle released, driven only when asserted
// - Host up, confirm held 4 s: reset 1 s
// - Reset shows message, then reboot; commands ignored meanwhile
// - Host down, confirm 0.25 s: power pulse, reboot
// - Host up, cancel held 4 s: power-off pulse
// - Cancel still held extends pulse up to 5 s
// - Blank option, host down: blank display, backlight off
// - Blank option, sense rising: full reboot
// - Mask bits select auto, reset and power polarity
// - Mask bits enable blank and three key functions
// - Switch command 0x1C, one or two bytes, reply 0x5C
// - Second byte is pulse length, default 1 s
// - Watchdog command 0x1D; zero timeout disables it
// - Watchdog expiry pulses host reset with polarity
// - Watchdog off at power-up and after expiry
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module hpr_top #(
    parameter int unsigned TICK_CYCLES = hpr_pkg::TICK_CYCLES
) (
    input wire logic i_clk,                // 10 MHz system clock
    input wire logic i_rstn,               // Async reset, active low
    input wire logic i_wb_cyc,             // Wishbone cycle
    input wire logic i_wb_stb,             // Wishbone strobe
    input wire logic i_wb_we,              // Wishbone write enable
    input wire logic [7:0] i_wb_adr,       // Wishbone byte address
    input wire logic [31:0] i_wb_dat,      // Wishbone write data
    input wire logic [3:0] i_wb_sel,       // Wishbone byte enables
    output logic [31:0] o_wb_dat,          // Wishbone read data
    output logic o_wb_ack,                 // Wishbone acknowledge
    input wire logic i_host_sense,         // Host-alive sense pin
    input wire logic i_key_confirm,        // Confirm key, high when pressed
    input wire logic i_key_cancel,         // Cancel key, high when pressed
    input wire logic i_pwr_i,              // Power control pin level
    output logic o_pwr_o,                  // Power control drive level
    output logic o_pwr_oe,                 // Power control output enable
    input wire logic i_rst_i,              // Reset control pin level
    output logic o_rst_o,                  // Reset control drive level
    output logic o_rst_oe,                 // Reset control output enable
    output logic o_blank,                  // Display blanked
    output logic o_backlight,              // Backlight on
    output hpr_pkg::hpr_msg_t o_msg,       // Message shown on display
    output logic o_reboot                  // One-cycle self reboot pulse
);
    import hpr_pkg::*;

    logic [3:0] sync_q;
    logic sense, key_ok, key_cancel, pwr_pin, rst_pin;
    logic tick;
    hpr_state_t state_q;
    hpr_msg_t msg_q;
    logic [7:0] func_q, pulse_len_q;
    logic [7:0] ok_cnt_q, cancel_cnt_q, pulse_cnt_q;
    logic pulse_is_on_q;
    logic lockout_q;
    logic sense_prev_q;
    logic wd_en_q;
    logic [12:0] wd_cnt_q;
    logic pwr_idle_q, rst_idle_q;
    logic [7:0] reply_q, reply_seq_q;
    logic [31:0] rdata_q;
    logic ack_q;
    hpr_cmd_t cmd;
    logic cmd_wr, sw_ok, wd_ok, cmd_ok;
    logic go_reset, go_on, go_off, wd_fire, sense_rise;
    hpr_status_t status;

    hpr_sync #(
        .W(4)
    ) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_rst_i, i_pwr_i, i_key_cancel, i_key_confirm}),
        .o_q(sync_q)
    );

    assign key_ok = sync_q[0];
    assign key_cancel = sync_q[1];
    assign pwr_pin = sync_q[2];
    assign rst_pin = sync_q[3];

    // Sense has its own pair so its previous value can be kept apart
    hpr_sync #(
        .W(1)
    ) u_sense (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d(i_host_sense),
        .o_q(sense)
    );

    hpr_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_clear(1'b0),
        .o_tick(tick)
    );

    // Active drive level: auto follows the opposite of the idle level
    function automatic logic drive_level(input logic auto_pol, input logic inv,
                                         input logic idle);
        drive_level = auto_pol ? ~idle : inv;
    endfunction

    // Wishbone: ack one cycle after request, write lands on the ack edge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
        end
    end

    assign cmd = hpr_cmd_t'(i_wb_dat);
    assign cmd_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_q && (i_wb_adr == ADR_CMD)
                    && (i_wb_sel == SEL_ALL);
    assign sw_ok = (cmd.kind == CMD_SWITCH) && (cmd.len == LEN_ONE || cmd.len == LEN_TWO);
    assign wd_ok = (cmd.kind == CMD_WATCHDOG) && (cmd.len == LEN_ONE);
    assign cmd_ok = cmd_wr && !lockout_q && (sw_ok || wd_ok);

    assign status = '{pad: '0, wd_secs: wd_cnt_q[12:WD_SHIFT], pad2: '0,
                      rst_drive: o_rst_oe, pwr_drive: o_pwr_oe, wd_en: wd_en_q,
                      lockout: lockout_q, msg: msg_q, backlight: o_backlight,
                      blank: o_blank, sense: sense};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= '0;
        end else if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q) begin
            unique case (i_wb_adr)
                ADR_REPLY: rdata_q <= {16'h0000, reply_seq_q, reply_q};
                ADR_STATUS: rdata_q <= status;
                ADR_CONFIG: rdata_q <= {16'h0000, pulse_len_q, func_q};
                default: rdata_q <= '0;
            endcase
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdata_q;

    // Replies: type with 0x40 on success, 0xc0 when refused
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reply_q <= '0;
            reply_seq_q <= '0;
        end else if (cmd_wr) begin
            reply_q <= cmd.kind | (cmd_ok ? RPL_OK : RPL_ERR);
            reply_seq_q <= reply_seq_q + 8'h01;
        end
    end

    // Switch configuration survives a self reboot, as a stored boot state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            func_q <= FUNC_RESET_VAL;
            pulse_len_q <= PULSE_LEN_DEFAULT;
        end else if (cmd_ok && sw_ok) begin
            func_q <= cmd.data0;
            pulse_len_q <= (cmd.len == LEN_TWO) ? cmd.data1 : PULSE_LEN_DEFAULT;
        end
    end

    // Key hold counters; any release clears, so no action fires early
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ok_cnt_q <= '0;
            cancel_cnt_q <= '0;
        end else begin
            if (!key_ok || state_q != ST_IDLE) begin
                ok_cnt_q <= '0;
            end else if (tick && ok_cnt_q != RESET_HOLD_TK) begin
                ok_cnt_q <= ok_cnt_q + 8'h01;
            end
            if (!key_cancel || state_q != ST_IDLE) begin
                cancel_cnt_q <= '0;
            end else if (tick && cancel_cnt_q != PWR_OFF_HOLD_TK) begin
                cancel_cnt_q <= cancel_cnt_q + 8'h01;
            end
        end
    end

    assign go_reset = sense && func_q[FN_KEY_RESET] && ok_cnt_q == RESET_HOLD_TK;
    assign go_on = !sense && func_q[FN_KEY_PWR_ON] && ok_cnt_q == PWR_ON_HOLD_TK;
    assign go_off = sense && func_q[FN_KEY_PWR_OFF]
                    && cancel_cnt_q == PWR_OFF_HOLD_TK;
    assign wd_fire = wd_en_q && wd_cnt_q == 13'h0001 && tick;
    assign sense_rise = func_q[FN_BLANK] && sense && !sense_prev_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sense_prev_q <= 1'b0;
        end else begin
            sense_prev_q <= sense;
        end
    end

    // Sequencer for pulses and self reboot
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            pulse_cnt_q <= '0;
            pulse_is_on_q <= 1'b0;
            msg_q <= MSG_BOOT;
            lockout_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    pulse_cnt_q <= '0;
                    if (sense_rise) begin
                        state_q <= ST_REBOOT;
                    end else if (go_reset || (wd_fire && !go_on && !go_off)) begin
                        state_q <= ST_RST_PULSE;
                        msg_q <= MSG_RESET;
                        lockout_q <= 1'b1;
                    end else if (go_on) begin
                        state_q <= ST_PWR_PULSE;
                        pulse_is_on_q <= 1'b1;
                        msg_q <= MSG_POWER_ON;
                    end else if (go_off) begin
                        state_q <= ST_PWR_PULSE;
                        pulse_is_on_q <= 1'b0;
                        msg_q <= MSG_POWER_OFF;
                    end
                end
                ST_RST_PULSE: begin
                    if (tick) begin
                        pulse_cnt_q <= pulse_cnt_q + 8'h01;
                    end
                    if (tick && pulse_cnt_q == RESET_PULSE_TK - 8'h01) begin
                        state_q <= ST_REBOOT;
                    end
                end
                ST_PWR_PULSE: begin
                    if (tick) begin
                        pulse_cnt_q <= pulse_cnt_q + 8'h01;
                    end
                    if (tick && pulse_cnt_q + 8'h01 >= pulse_len_q) begin
                        pulse_cnt_q <= '0;
                        if (pulse_is_on_q) begin
                            state_q <= ST_REBOOT;
                        end else if (key_cancel) begin
                            state_q <= ST_PWR_EXTEND;
                        end else begin
                            state_q <= ST_IDLE;
                            msg_q <= MSG_NONE;
                        end
                    end
                end
                ST_PWR_EXTEND: begin
                    if (tick) begin
                        pulse_cnt_q <= pulse_cnt_q + 8'h01;
                    end
                    if (!key_cancel || (tick && pulse_cnt_q == EXTEND_MAX_TK - 8'h01)) begin
                        state_q <= ST_IDLE;
                        msg_q <= MSG_NONE;
                    end
                end
                ST_REBOOT: begin
                    state_q <= ST_IDLE;
                    msg_q <= MSG_BOOT;
                    lockout_q <= 1'b0;
                    pulse_cnt_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reboot <= 1'b0;
        end else begin
            o_reboot <= (state_q == ST_REBOOT);
        end
    end

    // Watchdog in ticks; stops at one until the sequencer can take it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wd_en_q <= 1'b0;
            wd_cnt_q <= '0;
        end else if (cmd_ok && wd_ok) begin
            wd_en_q <= (cmd.data0 != 8'h00);
            wd_cnt_q <= {cmd.data0, WD_SHIFT'(0)};
        end else if (state_q == ST_IDLE && wd_fire && !go_on && !go_off && !sense_rise) begin
            wd_en_q <= 1'b0;
            wd_cnt_q <= '0;
        end else if (state_q == ST_REBOOT) begin
            wd_en_q <= 1'b0;
            wd_cnt_q <= '0;
        end else if (wd_en_q && tick && wd_cnt_q != 13'h0001) begin
            wd_cnt_q <= wd_cnt_q - 13'h0001;
        end
    end

    // Idle levels sampled only while released, for automatic polarity
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwr_idle_q <= 1'b1;
            rst_idle_q <= 1'b1;
        end else begin
            if (!o_pwr_oe) begin
                pwr_idle_q <= pwr_pin;
            end
            if (!o_rst_oe) begin
                rst_idle_q <= rst_pin;
            end
        end
    end

    // Pin drivers: released unless a pulse is in progress
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pwr_oe <= 1'b0;
            o_pwr_o <= 1'b0;
            o_rst_oe <= 1'b0;
            o_rst_o <= 1'b0;
        end else begin
            o_pwr_oe <= (state_q == ST_PWR_PULSE) || (state_q == ST_PWR_EXTEND);
            o_rst_oe <= (state_q == ST_RST_PULSE);
            o_pwr_o <= drive_level(func_q[FN_AUTO_POL], func_q[FN_POWER_INV],
                                   pwr_idle_q);
            o_rst_o <= drive_level(func_q[FN_AUTO_POL], func_q[FN_RESET_INV],
                                   rst_idle_q);
        end
    end

    // Display: blank and dark while host is down, keypad still live
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_blank <= 1'b0;
            o_backlight <= 1'b1;
            o_msg <= MSG_BOOT;
        end else begin
            o_blank <= func_q[FN_BLANK] && !sense && state_q == ST_IDLE;
            o_backlight <= !(func_q[FN_BLANK] && !sense && state_q == ST_IDLE);
            o_msg <= msg_q;
        end
    end

endmodule

//--- verif/hpr_host_model.sv
// Host board model: pulled-up switch lines and a host that powers on and off.
// Assumes the block's drive and enable outputs; sense answers after DLY clocks.
`timescale 1ns/1ps
module hpr_host_model #(
    parameter int DLY = 5
) (
    input wire logic i_clk,
    input wire logic i_pwr_o,
    input wire logic i_pwr_oe,
    input wire logic i_rst_o,
    input wire logic i_rst_oe,
    output logic o_pwr_i,
    output logic o_rst_i,
    output logic o_sense,
    output logic [7:0] o_pwr_n,
    output logic [7:0] o_rst_n
);
    logic on_q = 1'b0;
    logic pq = 1'b0;
    logic rq = 1'b0;
    int cnt = 0;

    initial begin
        o_sense = 1'b0;
        o_pwr_n = 8'h0;
        o_rst_n = 8'h0;
    end
    // Released lines float to the board pull-up
    assign o_pwr_i = i_pwr_oe ? i_pwr_o : 1'b1;
    assign o_rst_i = i_rst_oe ? i_rst_o : 1'b1;
    always @(posedge i_clk) begin
        pq <= i_pwr_oe;
        rq <= i_rst_oe;
        if (pq && !i_pwr_oe) begin
            o_pwr_n <= o_pwr_n + 8'h1;
            on_q <= !on_q;
        end
        if (rq && !i_rst_oe) begin
            o_rst_n <= o_rst_n + 8'h1;
        end
        // Rails settle slowly; pulled up when on, driven low when off
        cnt <= (o_sense == on_q) ? 0 : cnt + 1;
        if (cnt >= DLY) begin
            o_sense <= on_q;
        end
    end
endmodule

//--- verif/hpr_top_properties.sv
// Checker for the host power and reset block ports.
// Assumes binding to hpr_top with a matching TICK_CYCLES.
`timescale 1ns/1ps
module hpr_top_chk
    import hpr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic o_pwr_o,
    input wire logic o_pwr_oe,
    input wire logic o_rst_oe,
    input wire logic o_blank,
    input wire logic o_backlight,
    input wire hpr_msg_t o_msg,
    input wire logic o_reboot
);
    logic [15:0] rcnt_q;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Length of the current reset drive, in clocks
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rcnt_q <= 16'h0;
        end else begin
            rcnt_q <= o_rst_oe ? rcnt_q + 16'h1 : 16'h0;
        end
    end

    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    chk_bus_answer: assert property (s_req |=> s_ack)
        else $error("bus answer missing or too long");
    chk_pwr_msg: assert property ($rose(o_pwr_oe) |-> ##[0:1]
        (o_msg == MSG_POWER_ON || o_msg == MSG_POWER_OFF))
        else $error("power drive without message");
    chk_drive_steady: assert property (o_pwr_oe && $past(o_pwr_oe) |-> $stable(o_pwr_o))
        else $error("power drive level moved");
    chk_rst_len: assert property ($fell(o_rst_oe) |->
        rcnt_q >= 31 * TICK_CYCLES && rcnt_q <= 33 * TICK_CYCLES + 2)
        else $error("reset pulse length wrong");
    chk_rst_msg: assert property (o_rst_oe && $past(o_rst_oe) |-> o_msg == MSG_RESET)
        else $error("reset message missing");
    chk_rst_boot: assert property ($fell(o_rst_oe) |-> ##[0:3] o_msg == MSG_BOOT)
        else $error("no reboot after reset pulse");
    chk_one_reboot: assert property (o_reboot |=> !o_reboot)
        else $error("reboot pulse too long");
    chk_blank_dark: assert property (o_blank |-> !o_backlight)
        else $error("backlight on while blanked");
endmodule

bind hpr_top hpr_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_hpr_top_chk (.i_clk, .i_rstn,
    .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_pwr_o, .o_pwr_oe, .o_rst_oe, .o_blank,
    .o_backlight, .o_msg, .o_reboot);

//--- verif/tb_hpr_top.sv
// Self-checking bench for hpr_top with a host board model.
// Assumes a short tick prescaler so second-long holds stay brief.
`timescale 1ns/1ps
module tb_hpr_top;
    import hpr_pkg::*;
    localparam int T = 8;
    logic i_clk, i_rstn, cyc, stb, we, kc, kx;
    logic [7:0] adr, m, npwr, nrst;
    logic [31:0] wd, rd;
    integer seed;
    logic [3:0] sel;
    logic [31:0] o_wb_dat;
    logic o_wb_ack, o_pwr_o, o_pwr_oe, o_rst_o, o_rst_oe, o_blank, o_backlight, o_reboot;
    logic pwr_i, rst_i, sense;
    hpr_msg_t o_msg;
    int bad_count, samples_checked, w, e, len, ncmd;

    hpr_top #(.TICK_CYCLES(T)) i_hpr_top (.i_clk, .i_rstn, .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(sel), .o_wb_dat, .o_wb_ack,
        .i_host_sense(sense), .i_key_confirm(kc), .i_key_cancel(kx), .i_pwr_i(pwr_i),
        .o_pwr_o, .o_pwr_oe, .i_rst_i(rst_i), .o_rst_o, .o_rst_oe, .o_blank, .o_backlight,
        .o_msg, .o_reboot);
    hpr_host_model #(.DLY(12)) i_hpr_host_model (.i_clk, .i_pwr_o(o_pwr_o),
        .i_pwr_oe(o_pwr_oe), .i_rst_o(o_rst_o), .i_rst_oe(o_rst_oe), .o_pwr_i(pwr_i),
        .o_rst_i(rst_i), .o_sense(sense), .o_pwr_n(npwr), .o_rst_n(nrst));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task chk_rng(input string nm, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // Holds the request until ack is sampled, then releases for a cycle
    // No wait limit of its own: only the bench watchdog ends a hang
    task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wd <= d;
        sel <= SEL_ALL;
        @(posedge i_clk);
        while (o_wb_ack !== 1'b1) begin
            @(posedge i_clk);
        end
        rd = o_wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask

    task cmd(input logic [7:0] k, input logic [1:0] ln, input logic [7:0] d0, input logic [7:0] ex);
        ncmd++;
        wb(1'b1, ADR_CMD, {6'h0, ln, len[7:0], d0, k});
        wb(1'b0, ADR_REPLY, 32'h0);
        chk("reply", {16'h0, 8'(ncmd), ex}, {16'h0, rd[15:0]});
    endtask

    // Waits for a drive to start, then counts its clocks
    task pulse(input logic pw, input int lim, output int wdth);
        int n;
        n = 0;
        wdth = 0;
        while ((pw ? o_pwr_oe : o_rst_oe) !== 1'b1 && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        while ((pw ? o_pwr_oe : o_rst_oe) === 1'b1 && wdth < 4000) begin
            @(posedge i_clk);
            wdth++;
        end
    endtask

    initial begin
        seed = 32'h6ae1f1ad;
        {i_rstn, cyc, stb, we, kc, kx, adr, wd, sel} = '0;
        bad_count = 0;
        samples_checked = 0;
        len = 0;
        ncmd = 0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        chk("idle drive", 0, {o_pwr_oe, o_rst_oe});
        wb(1'b0, ADR_CONFIG, 32'h0);
        chk("config", 32'h2000, rd);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 0, rd);
        cmd(CMD_SWITCH, 2'h0, 8'hf0, 8'hdc);
        cmd(CMD_SWITCH, LEN_ONE, 8'hf0, 8'h5c);
        repeat (8) @(posedge i_clk);
        chk("blank", 2'b10, {o_blank, o_backlight});
        kc <= 1'b1;
        repeat (3 * T) @(posedge i_clk);
        kc <= 1'b0;
        repeat (12 * T) @(posedge i_clk);
        chk("early release", 0, npwr);
        kc <= 1'b1;
        pulse(1'b1, 20 * T, w);
        kc <= 1'b0;
        chk_rng("power on", 31 * T, 33 * T + 4, w);
        repeat (30) @(posedge i_clk);
        chk("unblank", 2'b01, {o_blank, o_backlight});
        cmd(CMD_WATCHDOG, LEN_ONE, 8'h1, 8'h5d);
        repeat (3) begin
            repeat (25 * T) @(posedge i_clk);
            cmd(CMD_WATCHDOG, LEN_ONE, 8'h1, 8'h5d);
        end
        chk("refreshed", 0, nrst);
        cmd(CMD_WATCHDOG, LEN_ONE, 8'h0, 8'h5d);
        repeat (40 * T) @(posedge i_clk);
        chk("disabled", 0, nrst);
        cmd(CMD_WATCHDOG, LEN_ONE, 8'h1, 8'h5d);
        fork
            pulse(1'b0, 40 * T, w);
            begin
                wait (o_rst_oe === 1'b1);
                repeat (T) @(posedge i_clk);
                cmd(CMD_WATCHDOG, LEN_ONE, 8'h1, 8'hdd);
            end
        join
        chk_rng("expiry", 31 * T, 33 * T + 4, w);
        repeat (40 * T) @(posedge i_clk);
        chk("one expiry", 1, nrst);
        kc <= 1'b1;
        pulse(1'b0, 140 * T, w);
        kc <= 1'b0;
        chk_rng("key reset", 31 * T, 33 * T + 4, w);
        len = 4 + ($random(seed) & 7);
        e = 2 + ($random(seed) & 7);
        cmd(CMD_SWITCH, LEN_TWO, 8'hf0, 8'h5c);
        wb(1'b0, ADR_CONFIG, 32'h0);
        chk("config", {16'h0, len[7:0], 8'hf0}, rd);
        kx <= 1'b1;
        fork
            pulse(1'b1, 140 * T, w);
            begin
                wait (o_pwr_oe === 1'b1);
                repeat ((len + e) * T) @(posedge i_clk);
                kx <= 1'b0;
            end
        join
        chk_rng("power off", (len + e - 1) * T, (len + e + 2) * T, w);
        repeat (30) @(posedge i_clk);
        chk("host off", 0, sense);
        for (int i = 0; i < 4; i++) begin
            m = 8'(i << 1);
            cmd(CMD_SWITCH, LEN_ONE, m, 8'h5c);
            chk("polarity", {m[2], m[1]}, {o_pwr_o, o_rst_o});
        end
        // Auto overrides the invert bits: released lines idle high, so drive low
        cmd(CMD_SWITCH, LEN_ONE, 8'h07, 8'h5c);
        chk("auto polarity", 0, {o_pwr_o, o_rst_o});
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        report_and_stop;
    end
endmodule
